// File: wx_cfg.svh
// constants for the cyclic weight exchange link, device end and controller end
`ifndef WX_CFG_SVH
`define WX_CFG_SVH
`define WX_SLOTS          4
`define WX_WORD_W         16
`define WX_SEL_LSB        0
`define WX_SEL_W          3
`define WX_CMD_LOAD_TARE  3
`define WX_CMD_CLR_TARE   4
`define WX_CMD_TARE       5
`define WX_CMD_PRINT      6
`define WX_CMD_ZERO       7
`define WX_CMD_TARGET     8
`define WX_CMD_MSG_LSB    9
`define WX_CMD_OUT_LSB    12
`define WX_CMD_LOAD_TGT   15
`define WX_ST_TGT_LSB     0
`define WX_ST_CMP_LSB     3
`define WX_ST_ENTER       8
`define WX_ST_IN_LSB      9
`define WX_ST_MOTION      12
`define WX_ST_NET         13
`define WX_ST_UPDATING    14
`define WX_ST_DATA_OK     15
`define WX_REFRESH_CYC    4
`define WX_CLK_HZ         40000000
`define WX_RECOVERY_MS    200
`define WX_RECOVERY_CYC   ((`WX_CLK_HZ / 1000) * `WX_RECOVERY_MS)
`define WX_A_CTRL         8'h00
`define WX_A_PERIOD       8'h04
`define WX_A_WDINT        8'h08
`define WX_A_STATUS       8'h0c
`define WX_A_MASK         8'h10
`define WX_A_INFO         8'h14
`define WX_A_OUT0         8'h20
`define WX_A_CMD          8'h30
`define WX_A_IN           8'h40
`define WX_PERIOD_RST     16'h0050
`define WX_WDINT_RST      16'h0080
`define WX_EV_NEWDATA     0
`define WX_EV_FAULT       1
`define WX_EV_WDSHORT     2
`define WX_EV_W           3
`endif

// File: wx_pkg.sv
// types shared by both ends of the cyclic weight exchange
package wx_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic [2:0] {
    SEL_GROSS = 3'h0, SEL_NET = 3'h1, SEL_DISP = 3'h2,
    SEL_TARE = 3'h3, SEL_TARGET = 3'h4, SEL_RATE = 3'h5
  } sel_t;
  typedef enum logic [1:0] {
    DEV_IDLE    = 2'b01,
    DEV_REFRESH = 2'b10
  } dev_state_t;
  typedef enum logic [1:0] {
    ROLE_CLIENT  = 2'h0,
    ROLE_MANAGER = 2'h1
  } ring_role_t;
endpackage

// File: wx_link_if.sv
// cyclic exchange link between controller and weighing device
`timescale 1ns/1ps
`default_nettype none
interface wx_link_if;
  import wx_pkg::*;
  logic       upd;          // one-cycle pulse: a cyclic update arrives
  word_t      tare_val [4]; // controller output word 1 per slot
  word_t      cmd      [4]; // controller output word 2 per slot
  logic [15:0] wd_intervals; // watchdog interval count
  logic [15:0] upd_ticks;    // cycles per update interval
  logic       ring_manager; // controller holds the ring manager role
  word_t      weight   [4]; // device input word 1 per slot
  word_t      status   [4]; // device input word 2 per slot
  logic [2:0] slot_count;   // active slots, 1..4
  logic       fault;        // device in watchdog fault
  ring_role_t dev_role;     // device ring role
  modport device (input upd, tare_val, cmd, wd_intervals, upd_ticks, ring_manager,
                  output weight, status, slot_count, fault, dev_role);
  modport ctrl   (output upd, tare_val, cmd, wd_intervals, upd_ticks, ring_manager,
                  input weight, status, slot_count, fault, dev_role);
endinterface
`default_nettype wire

// File: wx_device.sv
// weighing device end of the cyclic integer/division exchange
// How it works
// - two words in, two words out per slot
// - one to four slots, set locally
// - word one weight, word two status
// - weight chosen by latest slot selection code
// - controller sends tare/target then command word
// - select bits pick data, any slot
// - scale actions only from slot one
// - read is input, write is output, controller view
// - fixed status word bit layout
// - fault when no update within watchdog
// - watchdog equals intervals times update time
// - controller manages ring, devices are clients; wx_ctrl takes the manager role only while ctrl bit 1 is set
// - diagnostic interrupts off when controller manages; wx_ctrl leaves that to software
// - updating bit set while refreshing, ignore data
// - data not ok clears flag, zeroes weight
// - select codes, above five means gross
// - commands act on rising edge, except target abort on falling edge
`include "wx_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module wx_device
  import wx_pkg::*;
(
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST,
  wx_link_if.device        LINK,
  input  wire logic [1:0]  I_SLOT_CFG,    // active slots minus one
  input  wire word_t       I_GROSS,
  input  wire word_t       I_NET,
  input  wire word_t       I_DISPLAYED,
  input  wire word_t       I_TARE,
  input  wire word_t       I_TARGET,
  input  wire word_t       I_RATE,
  input  wire logic [2:0]  I_TGT_STATE,
  input  wire logic [4:0]  I_CMP,         // comparators 1..5 in bits 0..4
  input  wire logic        I_ENTER_KEY,   // one-cycle keypad pulse
  input  wire logic [2:0]  I_DISC_IN,
  input  wire logic        I_MOTION,
  input  wire logic        I_NET_MODE,
  input  wire logic        I_POWERUP,
  input  wire logic        I_SETUP,
  input  wire logic        I_OVER_UNDER,
  input  wire logic        I_X10_MODE,
  output logic             O_LOAD_TARE,
  output logic             O_CLEAR_TARE,
  output logic             O_TARE,
  output logic             O_PRINT,
  output logic             O_ZERO,
  output logic             O_TARGET_START,
  output logic             O_TARGET_ABORT,
  output logic             O_LOAD_TARGET,
  output word_t            O_VALUE,
  output logic [2:0]       O_MSG_MODE,
  output logic [2:0]       O_DISC_OUT,
  output logic             O_FAULT
);

  // choose the weight quantity for one slot
  function automatic word_t pick_weight(input logic [2:0] sel);
    unique case (sel)
      SEL_NET:    pick_weight = I_NET;
      SEL_DISP:   pick_weight = I_DISPLAYED;
      SEL_TARE:   pick_weight = I_TARE;
      SEL_TARGET: pick_weight = I_TARGET;
      SEL_RATE:   pick_weight = I_RATE;
      default:    pick_weight = I_GROSS; // codes above five fall to gross
    endcase
  endfunction

  dev_state_t  state;
  dev_state_t  next_state;
  logic [2:0]  refresh_cnt;
  logic [2:0]  next_refresh_cnt;
  word_t       cmd_q      [4];
  word_t       next_cmd_q [4];
  word_t       tare_q;
  word_t       next_tare_q;
  word_t       prev_cmd;
  word_t       next_prev_cmd;
  word_t       weight_q      [4];
  word_t       next_weight_q [4];
  word_t       status_q      [4];
  word_t       next_status_q [4];
  logic        enter_flag;
  logic        next_enter_flag;
  logic [31:0] wd_cnt;
  logic [31:0] next_wd_cnt;
  logic        fault;
  logic        next_fault;
  logic [7:0]  act;
  logic [7:0]  next_act;
  logic [2:0]  msg_mode;
  logic [2:0]  next_msg_mode;
  logic [2:0]  disc_out;
  logic [2:0]  next_disc_out;
  logic [31:0] wd_limit;
  logic        data_ok;
  word_t       rise;
  word_t       fall;

  assign wd_limit = 32'(LINK.wd_intervals) * 32'(LINK.upd_ticks);
  assign data_ok  = !(I_POWERUP || I_SETUP || I_OVER_UNDER || I_X10_MODE);
  assign rise     = cmd_q[0] & ~prev_cmd;
  assign fall     = ~cmd_q[0] & prev_cmd;

  // refresh sequence: capture command words, hold updating flag, then publish
  always_comb begin
    next_state       = state;
    next_refresh_cnt = refresh_cnt;
    next_cmd_q       = cmd_q;
    next_tare_q      = tare_q;
    next_weight_q    = weight_q;
    next_status_q    = status_q;
    unique case (state)
      DEV_IDLE: begin
        if (LINK.upd) begin
          next_cmd_q       = LINK.cmd;
          next_tare_q      = LINK.tare_val[0];
          next_refresh_cnt = 3'(`WX_REFRESH_CYC - 1);
          next_state       = DEV_REFRESH;
          for (int s = 0; s < `WX_SLOTS; s++) begin
            next_status_q[s][`WX_ST_UPDATING] = 1'b1;
          end
        end
      end
      DEV_REFRESH: begin
        if (refresh_cnt != 3'h0) begin
          next_refresh_cnt = refresh_cnt - 3'h1;
        end else begin
          next_state = DEV_IDLE;
          for (int s = 0; s < `WX_SLOTS; s++) begin
            if (s <= int'(I_SLOT_CFG)) begin
              // each slot reports what its own select bits ask
              next_weight_q[s] = data_ok ?
                pick_weight(cmd_q[s][`WX_SEL_LSB +: `WX_SEL_W]) : 16'h0000;
              next_status_q[s] = '0;
              next_status_q[s][`WX_ST_TGT_LSB +: 3] = I_TGT_STATE;
              for (int c = 0; c < 5; c++) begin
                next_status_q[s][`WX_ST_CMP_LSB + c] = I_CMP[4 - c];        // comparator 5 lowest
              end
              next_status_q[s][`WX_ST_ENTER]       = enter_flag;
              next_status_q[s][`WX_ST_IN_LSB +: 3] = I_DISC_IN;
              next_status_q[s][`WX_ST_MOTION]      = I_MOTION;
              next_status_q[s][`WX_ST_NET]         = I_NET_MODE;
              next_status_q[s][`WX_ST_UPDATING]    = 1'b0;
              next_status_q[s][`WX_ST_DATA_OK]     = data_ok;
            end else begin
              next_weight_q[s] = 16'h0000;
              next_status_q[s] = 16'h0000;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      state       <= DEV_IDLE;
      refresh_cnt <= 3'h0;
      cmd_q       <= '{default: 16'h0000};
      tare_q      <= 16'h0000;
      weight_q    <= '{default: 16'h0000};
      status_q    <= '{default: 16'h0000};
    end else begin
      state       <= next_state;
      refresh_cnt <= next_refresh_cnt;
      cmd_q       <= next_cmd_q;
      tare_q      <= next_tare_q;
      weight_q    <= next_weight_q;
      status_q    <= next_status_q;
    end
  end

  // slot one command decoding; only slot one's word is ever looked at here
  always_comb begin
    next_prev_cmd   = prev_cmd;
    next_act        = 8'h00;
    next_msg_mode   = msg_mode;
    next_disc_out   = disc_out;
    next_enter_flag = enter_flag;
    if (state == DEV_REFRESH && refresh_cnt == 3'h0) begin
      next_prev_cmd = cmd_q[0];
      next_act[0]   = rise[`WX_CMD_LOAD_TARE];
      next_act[1]   = rise[`WX_CMD_CLR_TARE];
      next_act[2]   = rise[`WX_CMD_TARE];
      next_act[3]   = rise[`WX_CMD_PRINT];
      next_act[4]   = rise[`WX_CMD_ZERO];
      next_act[5]   = rise[`WX_CMD_TARGET];
      next_act[6]   = fall[`WX_CMD_TARGET];                // falling edge aborts target logic
      next_act[7]   = rise[`WX_CMD_LOAD_TGT];
      next_msg_mode = cmd_q[0][`WX_CMD_MSG_LSB +: 3];
      next_disc_out = cmd_q[0][`WX_CMD_OUT_LSB +: 3];
      // any change of the message bits releases the enter key flag
      if ((rise[`WX_CMD_MSG_LSB +: 3] | fall[`WX_CMD_MSG_LSB +: 3]) != 3'h0) begin
        next_enter_flag = 1'b0;
      end
    end
    if (I_ENTER_KEY) begin
      next_enter_flag = 1'b1;                              // key press wins over release
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      prev_cmd   <= 16'h0000;
      act        <= 8'h00;
      msg_mode   <= 3'h0;
      disc_out   <= 3'h0;
      enter_flag <= 1'b0;
    end else begin
      prev_cmd   <= next_prev_cmd;
      act        <= next_act;
      msg_mode   <= next_msg_mode;
      disc_out   <= next_disc_out;
      enter_flag <= next_enter_flag;
    end
  end

  // watchdog: counts cycles since the last update; a zero limit disables it
  always_comb begin
    next_wd_cnt = wd_cnt;
    next_fault  = fault;
    if (LINK.upd) begin
      next_wd_cnt = 32'h0;
      next_fault  = 1'b0;
    end else if (wd_limit != 32'h0 && wd_cnt >= wd_limit) begin
      next_fault  = 1'b1;
    end else begin
      next_wd_cnt = wd_cnt + 32'h1;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      wd_cnt <= 32'h0;
      fault  <= 1'b0;
    end else begin
      wd_cnt <= next_wd_cnt;
      fault  <= next_fault;
    end
  end

  // link side outputs; the device never takes the manager role
  assign LINK.weight     = weight_q;
  assign LINK.status     = status_q;
  assign LINK.slot_count = {1'b0, I_SLOT_CFG} + 3'h1;
  assign LINK.fault      = fault;
  assign LINK.dev_role   = ROLE_CLIENT;

  assign O_LOAD_TARE    = act[0];
  assign O_CLEAR_TARE   = act[1];
  assign O_TARE         = act[2];
  assign O_PRINT        = act[3];
  assign O_ZERO         = act[4];
  assign O_TARGET_START = act[5];
  assign O_TARGET_ABORT = act[6];
  assign O_LOAD_TARGET  = act[7];
  assign O_VALUE        = tare_q;
  assign O_MSG_MODE     = msg_mode;
  assign O_DISC_OUT     = disc_out;
  assign O_FAULT        = fault;

endmodule // wx_device
`default_nettype wire

// File: wx_ctrl.sv
// controller end of the cyclic weight exchange, steered over an APB register file
`include "wx_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module wx_ctrl
  import wx_pkg::*;
#(
  parameter int unsigned RECOVERY_CYC = `WX_RECOVERY_CYC
)(
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST,
  wx_link_if.ctrl          LINK,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic [31:0]      O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  output logic             O_IRQ
);

  // slot index of an address inside a four-word bank
  function automatic logic [1:0] slot_of(input logic [7:0] a);
    slot_of = a[3:2];
  endfunction

  // status word of slot one as last captured; a change of it is a new-data event
  function automatic word_t status_w0_prev();
    status_w0_prev = in_img[0][31:16];
  endfunction

  logic [2:0]  ctrl;
  logic [2:0]  next_ctrl;
  logic [15:0] period;
  logic [15:0] next_period;
  logic [15:0] wdint;
  logic [15:0] next_wdint;
  word_t       out0      [4];
  word_t       next_out0 [4];
  word_t       cmd       [4];
  word_t       next_cmd  [4];
  logic [31:0] in_img      [4];
  logic [31:0] next_in_img [4];
  logic [2:0]  status;
  logic [2:0]  next_status;
  logic [2:0]  mask;
  logic [2:0]  next_mask;
  logic [15:0] tick;
  logic [15:0] next_tick;
  logic        upd;
  logic        next_upd;
  logic        fault_d;
  logic        next_fault_d;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        wr;
  logic        rd;
  logic [2:0]  ev;
  logic        stable;
  logic        wd_short;

  assign wr       = I_PSEL && I_PENABLE && I_PWRITE;
  assign rd       = I_PSEL && !I_PENABLE && !I_PWRITE;
  assign wd_short = (32'(wdint) * 32'(period)) <= RECOVERY_CYC;
  assign stable   = !LINK.status[0][`WX_ST_UPDATING];

  // register writes and cyclic update timer
  always_comb begin
    next_ctrl   = ctrl;
    next_period = period;
    next_wdint  = wdint;
    next_mask   = mask;
    next_out0   = out0;
    next_cmd    = cmd;
    next_tick   = tick;
    next_upd    = 1'b0;
    if (wr) begin
      unique case (I_PADDR & 8'hf0)
        `WX_A_OUT0: next_out0[slot_of(I_PADDR)] = I_PWDATA[15:0];
        `WX_A_CMD:  next_cmd[slot_of(I_PADDR)]  = I_PWDATA[15:0];
        default: begin
          if (I_PADDR == `WX_A_CTRL)   next_ctrl   = I_PWDATA[2:0];
          if (I_PADDR == `WX_A_PERIOD) next_period = I_PWDATA[15:0];
          if (I_PADDR == `WX_A_WDINT)  next_wdint  = I_PWDATA[15:0];
          if (I_PADDR == `WX_A_MASK)   next_mask   = I_PWDATA[2:0];
        end
      endcase
    end
    if (ctrl[0] && period != 16'h0) begin
      if (tick >= period - 16'h1) begin
        next_tick = 16'h0;
        next_upd  = 1'b1;
      end else begin
        next_tick = tick + 16'h1;
      end
    end else begin
      next_tick = 16'h0;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      ctrl   <= 3'h0;
      period <= `WX_PERIOD_RST;
      wdint  <= `WX_WDINT_RST;
      mask   <= 3'h0;
      out0   <= '{default: 16'h0000};
      cmd    <= '{default: 16'h0000};
      tick   <= 16'h0;
      upd    <= 1'b0;
    end else begin
      ctrl   <= next_ctrl;
      period <= next_period;
      wdint  <= next_wdint;
      mask   <= next_mask;
      out0   <= next_out0;
      cmd    <= next_cmd;
      tick   <= next_tick;
      upd    <= next_upd;
    end
  end

  // input image, sticky events and read data; a new event beats a read clear
  always_comb begin
    next_in_img  = in_img;
    next_fault_d = LINK.fault;
    ev           = 3'h0;
    if (stable && LINK.status[0] != status_w0_prev()) begin
      ev[`WX_EV_NEWDATA] = 1'b1;
    end
    for (int s = 0; s < `WX_SLOTS; s++) begin
      if (stable) begin
        next_in_img[s] = {LINK.status[s], LINK.weight[s]};
      end
    end
    ev[`WX_EV_FAULT]  = LINK.fault && !fault_d;
    ev[`WX_EV_WDSHORT] = wd_short && ctrl[1];
    next_status = ((rd && I_PADDR == `WX_A_STATUS) ? 3'h0 : status) | ev;
    next_rdata  = 32'h0;
    unique case (I_PADDR & 8'hf0)
      `WX_A_OUT0: next_rdata = {16'h0, out0[slot_of(I_PADDR)]};
      `WX_A_CMD:  next_rdata = {16'h0, cmd[slot_of(I_PADDR)]};
      `WX_A_IN:   next_rdata = in_img[slot_of(I_PADDR)];
      default: begin
        if (I_PADDR == `WX_A_CTRL)   next_rdata = {29'h0, ctrl};
        if (I_PADDR == `WX_A_PERIOD) next_rdata = {16'h0, period};
        if (I_PADDR == `WX_A_WDINT)  next_rdata = {16'h0, wdint};
        if (I_PADDR == `WX_A_STATUS) next_rdata = {29'h0, status};
        if (I_PADDR == `WX_A_MASK)   next_rdata = {29'h0, mask};
        if (I_PADDR == `WX_A_INFO)   next_rdata = {26'h0, LINK.dev_role, LINK.fault, LINK.slot_count};
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      in_img  <= '{default: 32'h0};
      status  <= 3'h0;
      fault_d <= 1'b0;
      rdata   <= 32'h0;
    end else begin
      in_img  <= next_in_img;
      status  <= next_status;
      fault_d <= next_fault_d;
      rdata   <= next_rdata;
    end
  end

  // link drive; keeping diagnostic interrupts off while managing the ring is up to software
  assign LINK.upd          = upd;
  assign LINK.tare_val     = out0;
  assign LINK.cmd          = cmd;
  assign LINK.wd_intervals = wdint;
  assign LINK.upd_ticks    = period;
  assign LINK.ring_manager = ctrl[1];
  assign O_PRDATA  = rdata;
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = 1'b0;
  assign O_IRQ     = |(status & mask);

endmodule // wx_ctrl
`default_nettype wire

// File: wx_link_props.sv
// assertions on the cyclic exchange link between controller end and device end
`timescale 1ns/1ps
`default_nettype none
module wx_link_props
  import wx_pkg::*;
(
  input wire logic        I_CLK_SYS,
  input wire logic        I_RST,
  input wire logic        upd,
  input wire logic [15:0] wd_intervals,
  input wire logic [15:0] upd_ticks,
  input wire word_t       weight [4],
  input wire word_t       status [4],
  input wire logic [2:0]  slot_count,
  input wire logic        fault,
  input wire ring_role_t  dev_role
);
  logic [31:0] since;
  logic [31:0] next_since;
  logic        armed;
  logic        next_armed;
  wire  [31:0] limit = 32'(wd_intervals) * 32'(upd_ticks);

  // cycles since the last update; saturates so a long pause cannot wrap into a false pass
  always_comb begin
    next_since = upd ? 32'h0 : ((since == 32'hffffffff) ? since : since + 32'h1);
    next_armed = armed | upd;
  end

  // helper registers only; armed stays low until the first update so reset time is not counted
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      since <= 32'h0;
      armed <= 1'b0;
    end else begin
      since <= next_since;
      armed <= next_armed;
    end
  end

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);

  chk_busy_follows_upd: assert property (upd && !status[0][14] |=> status[0][14])
    else $error("update did not raise the busy bit");
  chk_busy_has_cause: assert property ($rose(status[0][14]) |-> $past(upd))
    else $error("busy bit rose without an update");
  chk_busy_length: assert property ($rose(status[0][14]) |-> status[0][14][*4] ##1 !status[0][14])
    else $error("busy bit length wrong");
  chk_words_at_refresh: assert property (($changed(weight[0]) || $changed(status[0][13:0])) |-> $fell(status[0][14]))
    else $error("slot words changed outside a refresh");
  chk_slot_range: assert property (slot_count inside {[3'h1:3'h4]})
    else $error("slot count out of range");
  chk_role_client: assert property (dev_role == ROLE_CLIENT)
    else $error("device left the client role");
  chk_fault_clears: assert property (upd |=> !fault)
    else $error("fault held after an update");
  chk_fault_not_early: assert property ($rose(fault) |-> armed && limit != 32'h0 && since + 32'h2 >= limit)
    else $error("fault came before the watchdog interval");
  chk_fault_not_late: assert property (armed && limit != 32'h0 && since > limit + 32'h3 |-> fault)
    else $error("fault missing after the watchdog interval");
  chk_bad_data_zero: assert property (!status[0][15] |-> weight[0] == 16'h0)
    else $error("weight not zero while data not ok");

  cover property ($rose(fault));
  cover property ($fell(status[0][14]) && !status[0][15]);
  cover property ($fell(status[0][14]) && status[0][15]);
endmodule // wx_link_props
`default_nettype wire

// File: slot_cyclic_weight_exchange_tb.sv
// self-checking bench: controller end and device end joined by the link interface
`include "wx_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module slot_cyclic_weight_exchange_tb;
  import wx_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        irq;
  logic        fault;
  logic [31:0] rd;
  word_t       src [6] = '{16'h0101, 16'h0202, 16'h0303, 16'h0404, 16'h0505, 16'h0606};
  word_t       value;
  logic [3:0]  bad = 4'h0;
  logic [2:0]  tgt = 3'h5;
  logic [4:0]  cmp = 5'h01;
  logic [2:0]  disc = 3'h2;
  logic        motion = 1'b1;
  logic        netm = 1'b0;
  logic        enter = 1'b0;
  logic [7:0]  act;
  logic [2:0]  msg;
  logic [2:0]  dout;
  logic [1:0]  ncfg = 2'h3;
  int          npulse [8] = '{default: 0};
  int          n_errors = 0;
  int          n_compared = 0;
  int          n;

  wx_link_if link ();

  always #12.5 clk = ~clk;

  wx_ctrl #(.RECOVERY_CYC(100)) i_wx_ctrl (
    .I_CLK_SYS(clk), .I_RST(rst), .LINK(link), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(), .O_IRQ(irq));

  wx_device i_wx_device (
    .I_CLK_SYS(clk), .I_RST(rst), .LINK(link), .I_SLOT_CFG(ncfg), .I_GROSS(src[0]), .I_NET(src[1]),
    .I_DISPLAYED(src[2]), .I_TARE(src[3]), .I_TARGET(src[4]), .I_RATE(src[5]), .I_TGT_STATE(tgt),
    .I_CMP(cmp), .I_ENTER_KEY(enter), .I_DISC_IN(disc), .I_MOTION(motion), .I_NET_MODE(netm),
    .I_POWERUP(bad[0]), .I_SETUP(bad[1]), .I_OVER_UNDER(bad[2]), .I_X10_MODE(bad[3]),
    .O_LOAD_TARE(act[0]), .O_CLEAR_TARE(act[1]), .O_TARE(act[2]), .O_PRINT(act[3]), .O_ZERO(act[4]),
    .O_TARGET_START(act[5]), .O_TARGET_ABORT(act[6]), .O_LOAD_TARGET(act[7]), .O_VALUE(value),
    .O_MSG_MODE(msg), .O_DISC_OUT(dout), .O_FAULT(fault));

  wx_link_props i_wx_link_props (
    .I_CLK_SYS(clk), .I_RST(rst), .upd(link.upd), .wd_intervals(link.wd_intervals),
    .upd_ticks(link.upd_ticks), .weight(link.weight), .status(link.status),
    .slot_count(link.slot_count), .fault(link.fault), .dev_role(link.dev_role));

  // count action pulses; each is one cycle wide, so a level stuck high shows as many
  always @(posedge clk) begin
    for (int i = 0; i < 8; i++) begin
      if (act[i] === 1'b1) npulse[i]++;
    end
  end

  // expected status word from the scale inputs, bit layout worked out by hand
  function automatic word_t st(input logic ok);
    return {ok, 1'b0, netm, motion, disc, 1'b0, cmp[0], cmp[1], cmp[2], cmp[3], cmp[4], tgt};
  endfunction

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one apb transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 16) begin
      n_errors++;
      summarize();
    end
    @(posedge clk);
  endtask

  // three update periods of 32 cycles: enough for a refresh and capture on every slot
  task automatic wait_upd;
    repeat (96) @(posedge clk);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, `WX_A_PERIOD, 32'h0, rd);
    `CHECK("period", {16'h0, `WX_PERIOD_RST}, rd)
    apb(1'b0, `WX_A_WDINT, 32'h0, rd);
    `CHECK("wdint", {16'h0, `WX_WDINT_RST}, rd)
    apb(1'b0, `WX_A_INFO, 32'h0, rd);
    `CHECK("info", 32'h4, rd)
    apb(1'b0, 8'hfc, 32'h0, rd);
    `CHECK("unmapped", 32'h0, rd)
    apb(1'b1, `WX_A_PERIOD, 32'h20, rd);
    apb(1'b1, `WX_A_MASK, 32'h1, rd);
    apb(1'b1, `WX_A_CTRL, 32'h1, rd);
    // every select code, spread over all slots; codes 6 and 7 fall back to gross
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, `WX_A_CMD + 8'(4 * (c % 4)), 32'(c), rd);
      wait_upd();
      apb(1'b0, `WX_A_IN + 8'(4 * (c % 4)), 32'h0, rd);
      `CHECK("in_word", {st(1'b1), src[(c > 5) ? 0 : c]}, rd)
    end
    `CHECK("irq_on", 1'b1, irq)
    apb(1'b1, `WX_A_MASK, 32'h0, rd);
    `CHECK("irq_masked", 1'b0, irq)
    // each of the four not-ok conditions zeroes the weight and drops the ok bit
    for (int k = 0; k < 4; k++) begin
      bad <= 4'h1 << k;
      wait_upd();
      apb(1'b0, `WX_A_IN, 32'h0, rd);
      `CHECK("not_ok", {st(1'b0), 16'h0}, rd)
    end
    bad <= 4'h0;
    apb(1'b1, `WX_A_OUT0, 32'h1234, rd);
    // scale actions and target start: ignored from slot two, one pulse per rising bit from slot one
    for (int b = 0; b < 6; b++) begin
      apb(1'b1, `WX_A_CMD + 8'h4, 32'h1 << (3 + b), rd);
      wait_upd();
      `CHECK("other_slot", 0, npulse[b])
      apb(1'b1, `WX_A_CMD, 32'h1 << (3 + b), rd);
      wait_upd();
      `CHECK("one_pulse", 1, npulse[b])
      apb(1'b1, `WX_A_CMD, 32'h0, rd);
      apb(1'b1, `WX_A_CMD + 8'h4, 32'h0, rd);
    end
    `CHECK("tare_value", 16'h1234, value)
    // enter key sets bit 8 until the message bits change; clearing target start aborts
    enter <= 1'b1;
    @(posedge clk);
    enter <= 1'b0;
    wait_upd();
    apb(1'b0, `WX_A_IN, 32'h0, rd);
    `CHECK("enter_key", 1'b1, rd[24])
    apb(1'b1, `WX_A_CMD, 32'h9200, rd);
    wait_upd();
    apb(1'b0, `WX_A_IN, 32'h0, rd);
    `CHECK("enter_clear", 1'b0, rd[24])
    `CHECK("target_abort", 1, npulse[6])
    `CHECK("load_target", 1, npulse[7])
    `CHECK("msg_mode", 3'h1, msg)
    `CHECK("disc_out", 3'h1, dout)
    // watchdog: 4 intervals of 32 cycles, then stop the updates
    apb(1'b1, `WX_A_WDINT, 32'h4, rd);
    wait_upd();
    apb(1'b1, `WX_A_MASK, 32'h2, rd);
    apb(1'b1, `WX_A_CTRL, 32'h0, rd);
    apb(1'b0, `WX_A_STATUS, 32'h0, rd);
    n = 0;
    while (fault !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    // let the controller register the fault event before looking at the interrupt
    @(posedge clk);
    `CHECK("fault", 1'b1, fault)
    `CHECK("irq_fault", 1'b1, irq)
    apb(1'b0, `WX_A_STATUS, 32'h0, rd);
    `CHECK("st_fault", 32'h2, rd & 32'h2)
    apb(1'b0, `WX_A_STATUS, 32'h0, rd);
    `CHECK("st_cleared", 32'h0, rd)
    `CHECK("irq_cleared", 1'b0, irq)
    apb(1'b0, `WX_A_INFO, 32'h0, rd);
    `CHECK("info_fault", 32'hc, rd)
    // manager with a watchdog of 64 cycles, not above the 100-cycle recovery time
    apb(1'b1, `WX_A_WDINT, 32'h2, rd);
    apb(1'b1, `WX_A_CTRL, 32'h3, rd);
    wait_upd();
    `CHECK("fault_gone", 1'b0, fault)
    apb(1'b0, `WX_A_STATUS, 32'h0, rd);
    `CHECK("wd_short", 32'h4, rd & 32'h4)
    // a single active slot: the others read back as zeros
    ncfg <= 2'h0;
    wait_upd();
    apb(1'b0, `WX_A_IN + 8'h4, 32'h0, rd);
    `CHECK("idle_slot", 32'h0, rd)
    apb(1'b0, `WX_A_INFO, 32'h0, rd);
    `CHECK("info_one", 32'h1, rd)
    summarize();
  end
endmodule // slot_cyclic_weight_exchange_tb
`default_nettype wire
